//--- core/ddt_pkg.sv
/*
 * Package for the display transfer control block: register offsets,
 * field positions, reset values and AXI response codes.
 * Assumes an AXI4-Lite register bus with 32-bit data and byte addressing.
 */
`default_nettype none
package ddt_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_SRC_LOW   = 8'hb0;
    localparam logic [7:0]  IDX_SRC_MID   = 8'hb1;
    localparam logic [7:0]  IDX_SRC_HIGH  = 8'hb2;
    localparam logic [7:0]  IDX_WC_LOW    = 8'hb4;
    localparam logic [7:0]  IDX_BW_HIGH   = 8'hb5;
    localparam logic [7:0]  IDX_HC_MID    = 8'hb6;
    localparam logic [7:0]  IDX_BH_HIGH   = 8'hb7;
    localparam logic [7:0]  IDX_PWC_HIGH  = 8'hb8;
    localparam logic [7:0]  IDX_PW_HIGH   = 8'hb9;
    localparam logic [7:0]  IDX_CONFIG    = 8'hbf;
    // Field positions in the configuration register
    localparam int          CFG_START_BIT = 0;
    localparam int          CFG_MODE_BIT  = 1;
    // Reset value shared by all registers
    localparam logic [7:0]  REG_RESET     = 8'h00;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : ddt_pkg
`default_nettype wire

//--- core/ddt_fetch.sv
/*
 * Fetch sequencer: walks a continuous run or a rectangle of source words.
 * Assumes the memory port accepts one address per cycle when mem_ready.
 */
`timescale 1ns/1ps
`default_nettype none
module ddt_fetch #(
    parameter int AW = 24,              // Source address width
    parameter int CW = 19               // Count width
) (
    input  wire logic          mclk,    // Clock
    input  wire logic          rst,     // Sync reset, active high
    input  wire logic          go,      // One-cycle launch
    input  wire logic          block,   // 1: block mode
    input  wire logic [AW-1:0] base,    // Start address
    input  wire logic [CW-1:0] count,   // Continuous length
    input  wire logic [9:0]    bw,      // Block width
    input  wire logic [9:0]    bh,      // Block height
    input  wire logic [9:0]    pw,      // Picture width
    input  wire logic          mem_ready, // Memory takes address
    output logic               mem_valid, // Address offered
    output logic [AW-1:0]      mem_addr,  // Address
    output logic               busy     // Transfer running
);
    typedef enum logic [0:0] {S_IDLE, S_RUN} ddt_state_e;
    ddt_state_e    st_reg, st_next;
    logic [AW-1:0] row_reg, row_next, adr_reg, adr_next;
    logic [CW-1:0] left_reg, left_next;
    logic [9:0]    col_reg, col_next, lin_reg, lin_next;

    // Next state of the sequencer
    always_comb begin
        st_next   = st_reg;
        row_next  = row_reg;
        adr_next  = adr_reg;
        left_next = left_reg;
        col_next  = col_reg;
        lin_next  = lin_reg;
        case (st_reg)
            S_IDLE: begin
                if (go) begin
                    row_next  = base;
                    adr_next  = base;
                    left_next = count;
                    col_next  = bw;
                    lin_next  = bh;
                    // Empty transfer finishes at once
                    if (block ? (bw != 10'h000 && bh != 10'h000)
                              : (count != '0))
                        st_next = S_RUN;
                end
            end
            S_RUN: begin
                if (mem_ready) begin
                    if (!block) begin
                        adr_next  = adr_reg + AW'(1);
                        left_next = left_reg - CW'(1);
                        if (left_reg == CW'(1))
                            st_next = S_IDLE;
                    end else if (col_reg == 10'h001) begin
                        row_next = row_reg + AW'(pw);
                        adr_next = row_reg + AW'(pw);
                        col_next = bw;
                        lin_next = lin_reg - 10'h001;
                        if (lin_reg == 10'h001)
                            st_next = S_IDLE;
                    end else begin
                        adr_next = adr_reg + AW'(1);
                        col_next = col_reg - 10'h001;
                    end
                end
            end
            default: st_next = S_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_reg   <= S_IDLE;
            row_reg  <= '0;
            adr_reg  <= '0;
            left_reg <= '0;
            col_reg  <= '0;
            lin_reg  <= '0;
        end else begin
            st_reg   <= st_next;
            row_reg  <= row_next;
            adr_reg  <= adr_next;
            left_reg <= left_next;
            col_reg  <= col_next;
            lin_reg  <= lin_next;
        end
    end

    assign mem_valid = (st_reg == S_RUN);
    assign mem_addr  = adr_reg;
    assign busy      = (st_reg == S_RUN);

    row_step_a: assert property (@(posedge mclk) disable iff (rst)
        st_reg == S_RUN && block && mem_ready && col_reg == 10'h001
        |=> row_reg == $past(row_reg) + AW'($past(pw)))
        else $error("row step wrong");
endmodule // ddt_fetch
`default_nettype wire

//--- core/ddt_top.sv
/*
 * Display transfer control: AXI4-Lite register file and launch logic,
 * driving the fetch sequencer toward the source memory.
 * Assumes the bus master keeps one read and one write outstanding at most.
 */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ddt_top (
    input  wire logic        mclk,          // 125 MHz clock
    input  wire logic        rst,           // Sync reset, active high
    input  wire logic [11:0] s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [11:0] s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    output logic             mem_valid,     // Source address offered
    output logic [23:0]      mem_addr,      // Source word address
    input  wire logic        mem_ready      // Source takes address
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0]  src0_reg, src1_reg, src2_reg, src0_next, src1_next, src2_next;
    logic [7:0]  wc_reg, hc_reg, pwc_reg, wc_next, hc_next, pwc_next;
    logic [1:0]  bwh_reg, bhh_reg, pwh_reg, bwh_next, bhh_next, pwh_next;
    logic        mode_reg, mode_next, go_reg, go_next;
    logic        aw_reg, aw_next, w_reg, w_next;
    logic [9:0]  awi_reg, awi_next;
    logic [7:0]  wd_reg, wd_next;
    logic        wst_reg, wst_next;
    logic        bv_reg, bv_next, rv_reg, rv_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next;
    logic        ar_rdy_reg, ar_rdy_next;
    logic        busy_w, fvalid_w, fready_w;
    logic [23:0] faddr_w;
    logic        mvalid_reg, mvalid_next;
    logic [23:0] maddr_reg;

    // Index of a byte address; word aligned
    function automatic logic [7:0] reg_index(input logic [11:0] a);
        return a[9:2];
    endfunction

    // Index known to the register map
    function automatic logic mapped(input logic [7:0] i);
        if (i == ddt_pkg::IDX_SRC_LOW || i == ddt_pkg::IDX_SRC_MID)
            return 1'b1;
        else if (i == ddt_pkg::IDX_SRC_HIGH || i == ddt_pkg::IDX_WC_LOW)
            return 1'b1;
        else if (i == ddt_pkg::IDX_BW_HIGH || i == ddt_pkg::IDX_HC_MID)
            return 1'b1;
        else if (i == ddt_pkg::IDX_BH_HIGH || i == ddt_pkg::IDX_PWC_HIGH)
            return 1'b1;
        else if (i == ddt_pkg::IDX_PW_HIGH || i == ddt_pkg::IDX_CONFIG)
            return 1'b1;
        else
            return 1'b0;
    endfunction

    // ----------------------------------------------------------------
    // Write channel: takes address and data in either order
    // ----------------------------------------------------------------
    always_comb begin
        aw_next   = aw_reg;
        w_next    = w_reg;
        awi_next  = awi_reg;
        wd_next   = wd_reg;
        wst_next  = wst_reg;
        bv_next   = bv_reg;
        br_next   = br_reg;
        src0_next = src0_reg;
        src1_next = src1_reg;
        src2_next = src2_reg;
        wc_next   = wc_reg;
        hc_next   = hc_reg;
        pwc_next  = pwc_reg;
        bwh_next  = bwh_reg;
        bhh_next  = bhh_reg;
        pwh_next  = pwh_reg;
        mode_next = mode_reg;
        go_next   = 1'b0;
        if (s_axi_awvalid && !aw_reg && !bv_reg) begin
            aw_next  = 1'b1;
            awi_next = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && !w_reg && !bv_reg) begin
            w_next   = 1'b1;
            wd_next  = s_axi_wdata[7:0];
            wst_next = s_axi_wstrb[0];
        end
        if (aw_reg && w_reg) begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            bv_next = 1'b1;
            br_next = (awi_reg[9:8] == 2'h0 && mapped(awi_reg[7:0]))
                      ? ddt_pkg::RESP_OKAY : ddt_pkg::RESP_SLVERR;
            if (wst_reg && awi_reg[9:8] == 2'h0) begin
                if (awi_reg[7:0] == ddt_pkg::IDX_SRC_LOW)
                    src0_next = wd_reg;
                else if (awi_reg[7:0] == ddt_pkg::IDX_SRC_MID)
                    src1_next = wd_reg;
                else if (awi_reg[7:0] == ddt_pkg::IDX_SRC_HIGH)
                    src2_next = wd_reg;
                else if (awi_reg[7:0] == ddt_pkg::IDX_WC_LOW)
                    wc_next = wd_reg;
                else if (awi_reg[7:0] == ddt_pkg::IDX_BW_HIGH)
                    bwh_next = wd_reg[1:0];
                else if (awi_reg[7:0] == ddt_pkg::IDX_HC_MID)
                    hc_next = wd_reg;
                else if (awi_reg[7:0] == ddt_pkg::IDX_BH_HIGH)
                    bhh_next = wd_reg[1:0];
                else if (awi_reg[7:0] == ddt_pkg::IDX_PWC_HIGH)
                    pwc_next = wd_reg;
                else if (awi_reg[7:0] == ddt_pkg::IDX_PW_HIGH)
                    pwh_next = wd_reg[1:0];
                else if (awi_reg[7:0] == ddt_pkg::IDX_CONFIG) begin
                    mode_next = wd_reg[ddt_pkg::CFG_MODE_BIT];
                    go_next = wd_reg[ddt_pkg::CFG_START_BIT] && !busy_w;
                end
            end
        end
        if (bv_reg && s_axi_bready)
            bv_next = 1'b0;
    end

    // ----------------------------------------------------------------
    // Read channel: one cycle after address is taken
    // ----------------------------------------------------------------
    always_comb begin
        rv_next     = rv_reg;
        rr_next     = rr_reg;
        rd_next     = rd_reg;
        ar_rdy_next = !rv_reg;
        if (s_axi_arvalid && ar_rdy_reg) begin
            rv_next     = 1'b1;
            ar_rdy_next = 1'b0;
            rd_next     = 32'h0000_0000;
            rr_next     = ddt_pkg::RESP_OKAY;
            if (s_axi_araddr[11:10] != 2'h0 ||
                !mapped(reg_index(s_axi_araddr)))
                rr_next = ddt_pkg::RESP_SLVERR;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_SRC_LOW)
                rd_next[7:0] = src0_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_SRC_MID)
                rd_next[7:0] = src1_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_SRC_HIGH)
                rd_next[7:0] = src2_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_WC_LOW)
                rd_next[7:0] = wc_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_BW_HIGH)
                rd_next[1:0] = bwh_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_HC_MID)
                rd_next[7:0] = hc_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_BH_HIGH)
                rd_next[1:0] = bhh_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_PWC_HIGH)
                rd_next[7:0] = pwc_reg;
            else if (reg_index(s_axi_araddr) == ddt_pkg::IDX_PW_HIGH)
                rd_next[1:0] = pwh_reg;
            else begin
                // busy reads back on bit 0
                rd_next[ddt_pkg::CFG_MODE_BIT]  = mode_reg;
                rd_next[ddt_pkg::CFG_START_BIT] = busy_w || go_reg;
            end
        end else if (rv_reg && s_axi_rready) begin
            rv_next     = 1'b0;
            ar_rdy_next = 1'b0;
        end
    end

    // Register the bus and configuration state
    always_ff @(posedge mclk) begin
        if (rst) begin
            {src0_reg, src1_reg, src2_reg} <= {3{ddt_pkg::REG_RESET}};
            {wc_reg, hc_reg, pwc_reg} <= {3{ddt_pkg::REG_RESET}};
            bwh_reg    <= 2'h0;
            bhh_reg    <= 2'h0;
            pwh_reg    <= 2'h0;
            mode_reg   <= 1'b0;
            go_reg     <= 1'b0;
            aw_reg     <= 1'b0;
            w_reg      <= 1'b0;
            awi_reg    <= 10'h000;
            wd_reg     <= 8'h00;
            wst_reg    <= 1'b0;
            bv_reg     <= 1'b0;
            br_reg     <= 2'h0;
            rv_reg     <= 1'b0;
            rr_reg     <= 2'h0;
            rd_reg     <= 32'h0000_0000;
            ar_rdy_reg <= 1'b0;
            mvalid_reg <= 1'b0;
            maddr_reg  <= 24'h00_0000;
        end else begin
            {src0_reg, src1_reg, src2_reg} <= {src0_next, src1_next, src2_next};
            {wc_reg, hc_reg, pwc_reg} <= {wc_next, hc_next, pwc_next};
            bwh_reg    <= bwh_next;
            bhh_reg    <= bhh_next;
            pwh_reg    <= pwh_next;
            mode_reg   <= mode_next;
            go_reg     <= go_next;
            aw_reg     <= aw_next;
            w_reg      <= w_next;
            awi_reg    <= awi_next;
            wd_reg     <= wd_next;
            wst_reg    <= wst_next;
            bv_reg     <= bv_next;
            br_reg     <= br_next;
            rv_reg     <= rv_next;
            rr_reg     <= rr_next;
            rd_reg     <= rd_next;
            ar_rdy_reg <= ar_rdy_next;
            mvalid_reg <= mvalid_next;
            maddr_reg  <= faddr_w;
        end
    end

    // ----------------------------------------------------------------
    // Field assembly and sequencer
    // ----------------------------------------------------------------
    logic [18:0] count_w;
    logic [9:0]  bw_w, bh_w, pw_w;
    assign count_w = {pwc_reg[2:0], hc_reg, wc_reg};
    assign bw_w = {bwh_reg, wc_reg};
    assign bh_w = {bhh_reg, hc_reg};
    // picture width, low bits in block mode
    assign pw_w = {pwh_reg, pwc_reg[7:3], mode_reg ? pwc_reg[2:0] : 3'h0};

    // Offer is taken when the memory accepts the registered address
    assign fready_w    = mem_ready && mvalid_reg;
    // Offer drops one cycle after a take while the address steps
    assign mvalid_next = fvalid_w && !fready_w;

    ddt_fetch #(.AW(24), .CW(19)) u_fetch (
        .mclk      (mclk),
        .rst       (rst),
        .go        (go_reg),
        .block     (mode_reg),
        .base      ({src2_reg, src1_reg, src0_reg}),
        .count     (count_w),
        .bw        (bw_w),
        .bh        (bh_w),
        .pw        (pw_w),
        .mem_ready (fready_w),
        .mem_valid (fvalid_w),
        .mem_addr  (faddr_w),
        .busy      (busy_w)
    );

    assign s_axi_awready = !aw_reg && !bv_reg;
    assign s_axi_wready  = !w_reg && !bv_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_arready = ar_rdy_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rresp   = rr_reg;
    assign s_axi_rdata   = rd_reg;
    assign mem_valid     = mvalid_reg;
    assign mem_addr      = maddr_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // launch raises busy next cycle
    start_busy_a: assert property (@(posedge mclk) disable iff (rst)
        go_reg && (mode_reg ? (bw_w != 10'h000 && bh_w != 10'h000)
                            : (count_w != 19'h0_0000))
        |=> busy_w) else $error("start did not raise busy");
    busy_read_a: assert property (@(posedge mclk) disable iff (rst)
        s_axi_arvalid && ar_rdy_reg && busy_w &&
        reg_index(s_axi_araddr) == ddt_pkg::IDX_CONFIG
        && s_axi_araddr[11:10] == 2'h0 |=> rd_reg[0])
        else $error("busy not read back");
    go_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        go_reg |=> !go_reg) else $error("start bit stuck");
    count_form_a: assert property (@(posedge mclk) disable iff (rst)
        count_w[18:16] == pwc_reg[2:0]) else $error("count high bits wrong");
    pw_low_a: assert property (@(posedge mclk) disable iff (rst)
        !mode_reg |-> pw_w[2:0] == 3'h0) else $error("width low bits leak");
    mode_write_a: assert property (@(posedge mclk) disable iff (rst)
        aw_reg && w_reg && wst_reg && awi_reg == {2'h0, ddt_pkg::IDX_CONFIG}
        |=> mode_reg == $past(wd_reg[1])) else $error("mode not stored");
    base_addr_a: assert property (@(posedge mclk) disable iff (rst)
        go_reg && !busy_w |=> faddr_w == {src2_reg, src1_reg, src0_reg}
        || !busy_w) else $error("start address wrong");
    // Write response holds until taken
    resp_hold_a: assert property (@(posedge mclk) disable iff (rst)
        bv_reg && !s_axi_bready |=> bv_reg) else $error("response dropped");
    width_form_a: assert property (@(posedge mclk) disable iff (rst)
        bw_w[9:8] == bwh_reg) else $error("width high bits wrong");
    height_form_a: assert property (@(posedge mclk) disable iff (rst)
        bh_w[9:8] == bhh_reg) else $error("height high bits wrong");
    cont_run_c: cover property (@(posedge mclk) go_reg && !mode_reg);
    block_run_c: cover property (@(posedge mclk) go_reg && mode_reg);
    busy_poll_c: cover property (@(posedge mclk) rv_reg && rd_reg[0]);
endmodule // ddt_top
`default_nettype wire

//--- bench/ddt_src_mem.sv
/*
 * Source memory model: takes fetch addresses and logs them in order.
 * Assumes the block holds mem_valid and mem_addr until mem_ready.
 */
`timescale 1ns/1ps
`default_nettype none
module ddt_src_mem (
    input  wire logic        mclk,      // Clock
    input  wire logic        rst,       // Sync reset
    input  wire logic        slow,      // 1: accept every other cycle
    input  wire logic        mem_valid, // Address offered
    input  wire logic [23:0] mem_addr,  // Address
    output logic             mem_ready  // Address taken
);
    logic [23:0] log_q[$];
    logic        phase_reg;
    // Log every accepted address, toggle stall phase
    always @(posedge mclk) begin
        if (rst) begin
            phase_reg <= 1'b0;
            log_q.delete();
        end else begin
            phase_reg <= ~phase_reg;
            if (mem_valid && mem_ready) log_q.push_back(mem_addr);
        end
    end
    assign mem_ready = ~slow | phase_reg;
endmodule // ddt_src_mem
`default_nettype wire

//--- bench/tb_top.sv
/*
 * Bench: register file over AXI4-Lite, continuous and block fetches.
 * Assumes ddt_top and the source memory model ddt_src_mem.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin checks_done++; if ((g) !== (e)) begin \
    num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    logic        mclk = 1'b0, rst = 1'b1, slow = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, last_rd;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        mem_valid, mem_ready;
    logic [23:0] mem_addr;
    int          num_errors = 0, checks_done = 0;
    always #4 mclk = ~mclk;
    ddt_top uut (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mem_valid(mem_valid),
        .mem_addr(mem_addr), .mem_ready(mem_ready));
    ddt_src_mem mem (.mclk(mclk), .rst(rst), .slow(slow),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_ready(mem_ready));
    // ----------------------------------------------------------------
    // Bus tasks and verdict
    // ----------------------------------------------------------------
    task automatic test_done();
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic hang();
        num_errors++;
        test_done();
    endtask
    // Write one byte register, compare the response code
    task automatic wr(input logic [7:0] i, input logic [7:0] d,
                      input logic [1:0] er);
        bit done;
        @(posedge mclk);
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int k = 0; k < 64 && !done; k++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                done = 1;
                `CHK("bresp", er, bresp)
            end
        end
        if (!done) hang();
    endtask
    // Read one byte register, compare data and response
    task automatic rd(input logic [7:0] i, input logic [31:0] ed,
                      input logic [1:0] er, input bit cd = 1'b1);
        bit done;
        @(posedge mclk);
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 64 && !done; k++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                done = 1;
                last_rd = rdata;
                `CHK("rresp", er, rresp)
                if (er == ddt_pkg::RESP_OKAY && cd) `CHK("rdata", ed, rdata)
            end
        end
        if (!done) hang();
    endtask
    // Start, see busy, then poll until idle with start bit cleared
    task automatic run(input logic [7:0] mode);
        bit idle;
        wr(ddt_pkg::IDX_CONFIG, mode | 8'h01, ddt_pkg::RESP_OKAY);
        rd(ddt_pkg::IDX_CONFIG, {24'h0, mode | 8'h01}, 2'h0);
        for (int k = 0; k < 400 && !idle; k++) begin
            rd(ddt_pkg::IDX_CONFIG, 32'h0, 2'h0, 1'b0);
            idle = !last_rd[0];
        end
        if (!idle) hang();
        `CHK("cfg_idle", {24'h0, mode}, last_rd)
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    logic [7:0] idx[10] = '{8'hb0, 8'hb1, 8'hb2, 8'hb4, 8'hb5, 8'hb6,
                            8'hb7, 8'hb8, 8'hb9, 8'hbf};
    logic [7:0] msk[9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff,
                           8'h03, 8'hff, 8'h03};
    task automatic t_regs();
        foreach (idx[n]) rd(idx[n], 32'h0, ddt_pkg::RESP_OKAY);
        foreach (msk[n]) wr(idx[n], 8'hff, ddt_pkg::RESP_OKAY);
        foreach (msk[n]) rd(idx[n], {24'h0, msk[n]}, 2'h0);
        // Unmapped index is refused and reads back nothing
        wr(8'hb3, 8'h5a, ddt_pkg::RESP_SLVERR);
        rd(8'hb3, 32'h0, ddt_pkg::RESP_SLVERR);
        wr(ddt_pkg::IDX_CONFIG, 8'h02, ddt_pkg::RESP_OKAY);
        rd(ddt_pkg::IDX_CONFIG, 32'h2, ddt_pkg::RESP_OKAY);
    endtask
    task automatic t_cont();
        logic [23:0] b = 24'h123456;
        wr(8'hb0, 8'h56, 2'h0);
        wr(8'hb1, 8'h34, 2'h0);
        wr(8'hb2, 8'h12, 2'h0);
        wr(8'hb4, 8'h03, 2'h0);
        wr(8'hb6, 8'h01, 2'h0);
        wr(8'hb8, 8'hf8, 2'h0);
        run(8'h00);
        `CHK("count", 259, mem.log_q.size())
        `CHK("first", b, mem.log_q[0])
        `CHK("last", b + 24'd258, mem.log_q[258])
    endtask
    task automatic t_block();
        logic [23:0] b = 24'h000100;
        mem.log_q.delete();
        slow <= 1'b1;
        wr(8'hb0, 8'h00, 2'h0);
        wr(8'hb1, 8'h01, 2'h0);
        wr(8'hb2, 8'h00, 2'h0);
        wr(8'hb4, 8'h03, 2'h0);
        wr(8'hb5, 8'h00, 2'h0);
        wr(8'hb6, 8'h02, 2'h0);
        wr(8'hb7, 8'h00, 2'h0);
        wr(8'hb8, 8'h0a, 2'h0);
        wr(8'hb9, 8'h01, 2'h0);
        run(8'h02);
        `CHK("blk_n", 6, mem.log_q.size())
        for (int r = 0; r < 2; r++)
            for (int c = 0; c < 3; c++)
                `CHK("blk_a", b + r * 24'h10a + c, mem.log_q[r*3+c])
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_cont();
        t_block();
        test_done();
    end
endmodule // tb_top
`default_nettype wire
